// ---- inc/psd_regs.svh ----
`ifndef PSD_REGS_SVH
`define PSD_REGS_SVH

// Byte offsets on the APB bus
`define PSD_CTRL_OFF       8'h00
`define PSD_INLIM_OFF      8'h04
`define PSD_FBHI_OFF       8'h08
`define PSD_UDISP_OFF      8'h0C
`define PSD_FALLBACK_OFF   8'h10
`define PSD_SDWELL_OFF     8'h14
`define PSD_PDWELL_OFF     8'h18
`define PSD_FMAX_OFF       8'h1C
`define PSD_UPLIM_OFF      8'h20
`define PSD_INTSTS_OFF     8'h24
`define PSD_INTMSK_OFF     8'h28
`define PSD_STATUS_OFF     8'h2C

// Control register fields
`define PSD_CTRL_MODE_LSB  0
`define PSD_CTRL_REV_BIT   3
`define PSD_CTRL_REFM_BIT  4
`define PSD_CTRL_PROH_BIT  5
`define PSD_CTRL_DET_LSB   6
`define PSD_CTRL_UNIT_LSB  9

// Reset values (percent in 0.1 %, frequency in 0.01 Hz, time in 0.1 s)
`define PSD_CTRL_RST       12'h208
`define PSD_INLIM_RST      16'h2710
`define PSD_INLIM_MAX      16'h2710
`define PSD_FBLVL_RST      16'h03E8
`define PSD_FBLVL_MAX      16'h03E8
`define PSD_FBTIME_RST     8'h0A
`define PSD_UDVAL_RST      16'h2710
`define PSD_UDVAL_MAX      16'hEA60
`define PSD_UDDIG_RST      2'h2
`define PSD_FALLBACK_RST   16'h0BB8
`define PSD_DWTIME_MAX     8'h64
`define PSD_FMAX_RST       16'h1770
`define PSD_PCT_SCALE      32'h000003E8

// Time base
`define PSD_CLK_NS         25
`define PSD_TENTH_NS       100000000
`define PSD_TENTH_CYCLES   (`PSD_TENTH_NS / `PSD_CLK_NS)

`endif

// ---- inc/psd_pkg.sv ----
package psd_pkg;

  typedef logic [15:0] psd_word_t;

  typedef enum logic [2:0]
  {
    DW_IDLE  = 3'b001,
    DW_START = 3'b010,
    DW_STOP  = 3'b100
  } psd_dwell_t;

endpackage : psd_pkg

// ---- logic/psd_supervisor.sv ----
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "psd_regs.svh"

module psd_supervisor #(
  parameter int unsigned TENTH_CYCLES = `PSD_TENTH_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pid_active,
  input  wire logic              motor2_select,
  input  wire logic              feedback_loss_alarm,
  input  wire logic              accelerating,
  input  wire logic              decelerating,
  input  wire logic [15:0]       controller_input,
  input  wire psd_pkg::psd_word_t feedback,
  input  wire psd_pkg::psd_word_t target,
  input  wire logic [15:0]       controller_output,
  input  wire psd_pkg::psd_word_t freq_reference,
  input  wire psd_pkg::psd_word_t output_frequency,
  output logic      [15:0]       clamped_input,
  output logic      [23:0]       feedback_monitor,
  output logic      [23:0]       target_monitor,
  output logic      [1:0]        display_digits,
  output psd_pkg::psd_word_t     reference_monitor,
  output psd_pkg::psd_word_t     freq_command,
  output logic                   reverse_run,
  output logic                   output_stop,
  output logic                   dwell_hold,
  output logic                   feedback_high_out,
  output logic                   feedback_over_alarm,
  output logic                   irq
);
  import psd_pkg::*;

  logic [11:0] ctrl_q;
  logic [15:0] inlim_q;
  logic [15:0] fblvl_q;
  logic [7:0]  fbtime_q;
  logic [15:0] udval_q;
  logic [1:0]  uddig_q;
  logic [15:0] fallback_q;
  logic [15:0] sdw_f_q;
  logic [7:0]  sdw_t_q;
  logic [15:0] pdw_f_q;
  logic [7:0]  pdw_t_q;
  logic [15:0] fmax1_q;
  logic [15:0] fmax2_q;
  logic [15:0] uplim_q;
  logic [3:0]  sts_q;
  logic [3:0]  msk_q;

  logic [2:0]  mode;
  logic [2:0]  det_mode;
  logic        user_unit;
  logic        wr_en;
  logic [31:0] rd_d;
  logic        hit;

  assign mode      = ctrl_q[`PSD_CTRL_MODE_LSB +: 3];
  assign det_mode  = ctrl_q[`PSD_CTRL_DET_LSB +: 3];
  assign user_unit = (ctrl_q[`PSD_CTRL_UNIT_LSB +: 2] == 2'h3);
  assign wr_en     = psel && penable && pready && pwrite;

  // One wait state keeps prdata and pready both from flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_comb
  begin
    hit  = 1'b1;
    rd_d = 32'h00000000;
    if (paddr == `PSD_CTRL_OFF)
      rd_d = {20'h00000, ctrl_q};
    else if (paddr == `PSD_INLIM_OFF)
      rd_d = {16'h0000, inlim_q};
    else if (paddr == `PSD_FBHI_OFF)
      rd_d = {8'h00, fbtime_q, fblvl_q};
    else if (paddr == `PSD_UDISP_OFF)
      rd_d = {14'h0000, uddig_q, udval_q};
    else if (paddr == `PSD_FALLBACK_OFF)
      rd_d = {16'h0000, fallback_q};
    else if (paddr == `PSD_SDWELL_OFF)
      rd_d = {8'h00, sdw_t_q, sdw_f_q};
    else if (paddr == `PSD_PDWELL_OFF)
      rd_d = {8'h00, pdw_t_q, pdw_f_q};
    else if (paddr == `PSD_FMAX_OFF)
      rd_d = {fmax2_q, fmax1_q};
    else if (paddr == `PSD_UPLIM_OFF)
      rd_d = {16'h0000, uplim_q};
    else if (paddr == `PSD_INTSTS_OFF)
      rd_d = {28'h0000000, sts_q};
    else if (paddr == `PSD_INTMSK_OFF)
      rd_d = {28'h0000000, msk_q};
    else if (paddr == `PSD_STATUS_OFF)
      rd_d = {27'h0000000, output_stop, reverse_run, dwell_hold, feedback_high_out,
              feedback_over_alarm};
    else
      hit = 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_d;
      pslverr <= !hit;
    end
    else
      pslverr <= 1'b0;
  end

  // Out-of-range settings are dropped, keeping the previous value
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q     <= `PSD_CTRL_RST;
      inlim_q    <= `PSD_INLIM_RST;
      fblvl_q    <= `PSD_FBLVL_RST;
      fbtime_q   <= `PSD_FBTIME_RST;
      udval_q    <= `PSD_UDVAL_RST;
      uddig_q    <= `PSD_UDDIG_RST;
      fallback_q <= `PSD_FALLBACK_RST;
      sdw_f_q    <= 16'h0000;
      sdw_t_q    <= 8'h00;
      pdw_f_q    <= 16'h0000;
      pdw_t_q    <= 8'h00;
      fmax1_q    <= `PSD_FMAX_RST;
      fmax2_q    <= `PSD_FMAX_RST;
      uplim_q    <= `PSD_FMAX_RST;
      msk_q      <= 4'h0;
    end
    else if (wr_en)
    begin
      if (paddr == `PSD_CTRL_OFF)
        ctrl_q <= pwdata[11:0];
      else if (paddr == `PSD_INLIM_OFF && pwdata[15:0] <= `PSD_INLIM_MAX)
        inlim_q <= pwdata[15:0];
      else if (paddr == `PSD_FBHI_OFF && pwdata[15:0] <= `PSD_FBLVL_MAX)
      begin
        fblvl_q  <= pwdata[15:0];
        fbtime_q <= pwdata[23:16];
      end
      else if (paddr == `PSD_UDISP_OFF && user_unit && pwdata[15:0] != 16'h0000
               && pwdata[15:0] <= `PSD_UDVAL_MAX)
      begin
        udval_q <= pwdata[15:0];
        uddig_q <= pwdata[17:16];
      end
      else if (paddr == `PSD_FALLBACK_OFF)
        fallback_q <= pwdata[15:0];
      else if (paddr == `PSD_SDWELL_OFF && pwdata[23:16] <= `PSD_DWTIME_MAX)
      begin
        sdw_f_q <= pwdata[15:0];
        sdw_t_q <= pwdata[23:16];
      end
      else if (paddr == `PSD_PDWELL_OFF && pwdata[23:16] <= `PSD_DWTIME_MAX)
      begin
        pdw_f_q <= pwdata[15:0];
        pdw_t_q <= pwdata[23:16];
      end
      else if (paddr == `PSD_FMAX_OFF)
      begin
        fmax1_q <= pwdata[15:0];
        fmax2_q <= pwdata[31:16];
      end
      else if (paddr == `PSD_UPLIM_OFF)
        uplim_q <= pwdata[15:0];
      else if (paddr == `PSD_INTMSK_OFF)
        msk_q <= pwdata[3:0];
    end
  end

  // Input clamp, in 0.1 % of maximum frequency
  logic signed [16:0] cin;
  logic signed [16:0] lim_p;

  assign cin   = {controller_input[15], controller_input};
  assign lim_p = {1'b0, inlim_q};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      clamped_input <= 16'h0000;
    else if (cin > lim_p)
      clamped_input <= inlim_q;
    else if (cin < -lim_p)
      clamped_input <= 16'(-lim_p);
    else
      clamped_input <= controller_input;
  end

  // Feedback-high qualification, own prescaler so timing starts at the crossing
  logic        fb_above;
  logic        fb_armed;
  logic        fb_alarm_mode;
  logic [31:0] fb_pre_q;
  logic [7:0]  fb_cnt_q;

  assign fb_above      = feedback > fblvl_q;
  assign fb_armed      = pid_active || det_mode == 3'h3 || det_mode == 3'h4
                         || det_mode == 3'h5 || det_mode == 3'h7;
  assign fb_alarm_mode = det_mode == 3'h1 || det_mode == 3'h4;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fb_pre_q <= 32'h00000000;
      fb_cnt_q <= 8'h00;
    end
    else if (!fb_above || !fb_armed)
    begin
      fb_pre_q <= 32'h00000000;
      fb_cnt_q <= 8'h00;
    end
    else if (fb_pre_q == TENTH_CYCLES - 1)
    begin
      fb_pre_q <= 32'h00000000;
      if (fb_cnt_q != 8'hFF)
        fb_cnt_q <= fb_cnt_q + 8'h01;
    end
    else
      fb_pre_q <= fb_pre_q + 32'h00000001;
  end

  logic fb_det;

  assign fb_det = fb_above && fb_armed && fb_cnt_q >= fbtime_q;

  // Fault modes are handled by the drive's fault logic, not here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      feedback_high_out   <= 1'b0;
      feedback_over_alarm <= 1'b0;
    end
    else
    begin
      feedback_high_out   <= fb_det && det_mode != 3'h2 && det_mode != 3'h5;
      feedback_over_alarm <= fb_det && fb_alarm_mode;
    end
  end

  // User display scaling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      feedback_monitor <= 24'h000000;
      target_monitor   <= 24'h000000;
      display_digits   <= 2'h0;
    end
    else if (user_unit)
    begin
      feedback_monitor <= 24'((feedback * udval_q) / `PSD_PCT_SCALE);
      target_monitor   <= 24'((target * udval_q) / `PSD_PCT_SCALE);
      display_digits   <= uddig_q;
    end
    else
    begin
      feedback_monitor <= {8'h00, feedback};
      target_monitor   <= {8'h00, target};
      display_digits   <= 2'h0;
    end
  end

  // Frequency bounds
  logic [15:0] fmax;
  logic [15:0] flim;
  logic [15:0] fallback_b;
  logic [15:0] sdw_b;
  logic [15:0] pdw_b;

  assign fmax       = motor2_select ? fmax2_q : fmax1_q;
  assign flim       = (uplim_q < fmax) ? uplim_q : fmax;
  assign fallback_b = (fallback_q < flim) ? fallback_q : flim;
  assign sdw_b      = (sdw_f_q < flim) ? sdw_f_q : flim;
  assign pdw_b      = (pdw_f_q < flim) ? pdw_f_q : flim;

  // Dwell sequencer
  psd_dwell_t  dw_q;
  logic [31:0] dw_pre_q;
  logic [7:0]  dw_cnt_q;
  logic        sdw_done_q;
  logic        pdw_done_q;
  logic        dw_tick;
  logic        dw_end;

  assign dw_tick = dw_pre_q == TENTH_CYCLES - 1;
  assign dw_end  = dw_tick && (dw_cnt_q + 8'h01 >= (dw_q == DW_START ? sdw_t_q : pdw_t_q));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dw_q       <= DW_IDLE;
      dw_pre_q   <= 32'h00000000;
      dw_cnt_q   <= 8'h00;
      sdw_done_q <= 1'b0;
      pdw_done_q <= 1'b0;
    end
    else
    begin
      dw_pre_q <= (dw_q == DW_IDLE || dw_tick) ? 32'h00000000 : dw_pre_q + 32'h00000001;
      if (dw_q != DW_IDLE && dw_tick)
        dw_cnt_q <= dw_cnt_q + 8'h01;
      case (dw_q)
        DW_IDLE:
        begin
          dw_cnt_q <= 8'h00;
          if (output_frequency == 16'h0000)
            sdw_done_q <= 1'b0;
          if (accelerating)
            pdw_done_q <= 1'b0;
          if (accelerating && !sdw_done_q && sdw_t_q != 8'h00
              && output_frequency >= sdw_b)
            dw_q <= DW_START;
          else if (decelerating && !pdw_done_q && pdw_t_q != 8'h00
                   && output_frequency <= pdw_b && output_frequency != 16'h0000)
            dw_q <= DW_STOP;
        end
        DW_START:
          if (dw_end)
          begin
            dw_q       <= DW_IDLE;
            sdw_done_q <= 1'b1;
          end
        DW_STOP:
          if (dw_end)
          begin
            dw_q       <= DW_IDLE;
            pdw_done_q <= 1'b1;
          end
        default:
          dw_q <= DW_IDLE;
      endcase
    end
  end

  // Command path
  logic               pid_on;
  logic               trim;
  logic signed [17:0] ctrl_s;
  logic signed [17:0] sum_s;
  logic [15:0]        cmd_pid;
  logic               rev_d;
  logic               stop_d;
  logic [15:0]        cmd_d;

  assign pid_on = pid_active && mode != 3'h0;
  assign trim   = mode == 3'h3 || mode == 3'h4;
  assign ctrl_s = {{2{controller_output[15]}}, controller_output};
  assign sum_s  = $signed({2'b00, freq_reference}) + ctrl_s;

  always_comb
  begin
    rev_d   = 1'b0;
    stop_d  = 1'b0;
    cmd_pid = controller_output;
    if (trim)
    begin
      // Controller output is applied as is; only the final sum is limited, to 0 through 16'hFFFF
      if (sum_s < 0)
        cmd_pid = 16'h0000;
      else if (sum_s > 18'sh0FFFF)
        cmd_pid = 16'hFFFF;
      else
        cmd_pid = sum_s[15:0];
    end
    else if (controller_output[15])
    begin
      if (ctrl_q[`PSD_CTRL_REV_BIT] && !ctrl_q[`PSD_CTRL_PROH_BIT])
      begin
        cmd_pid = 16'(-ctrl_s);
        rev_d   = 1'b1;
      end
      else
      begin
        cmd_pid = 16'h0000;
        stop_d  = 1'b1;
      end
    end
    cmd_d = pid_on ? cmd_pid : freq_reference;
    if (pid_on && feedback_loss_alarm)
    begin
      cmd_d  = fallback_b;
      rev_d  = 1'b0;
      stop_d = 1'b0;
    end
    if (!pid_on)
    begin
      rev_d  = 1'b0;
      stop_d = 1'b0;
    end
    if (dw_q == DW_START)
      cmd_d = sdw_b;
    else if (dw_q == DW_STOP)
      cmd_d = pdw_b;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      freq_command      <= 16'h0000;
      reverse_run       <= 1'b0;
      output_stop       <= 1'b0;
      dwell_hold        <= 1'b0;
      reference_monitor <= 16'h0000;
    end
    else
    begin
      freq_command      <= cmd_d;
      reverse_run       <= rev_d;
      output_stop       <= stop_d;
      dwell_hold        <= dw_q != DW_IDLE;
      reference_monitor <= (pid_on && !ctrl_q[`PSD_CTRL_REFM_BIT]) ? cmd_pid
                                                                   : freq_reference;
    end
  end

  // Interrupts: set wins over a simultaneous write-one clear
  logic       loss_q;
  logic       fb_det_q;
  logic [3:0] ev;
  logic [3:0] clr;

  // Edge of the detector itself, so fault modes cannot re-set bit 0 every cycle
  assign ev  = {dw_q == DW_STOP && dw_end, dw_q == DW_START && dw_end,
                feedback_loss_alarm && !loss_q, fb_det && !fb_det_q};
  assign clr = (wr_en && paddr == `PSD_INTSTS_OFF) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      loss_q   <= 1'b0;
      fb_det_q <= 1'b0;
      sts_q    <= 4'h0;
      irq      <= 1'b0;
    end
    else
    begin
      loss_q   <= feedback_loss_alarm;
      fb_det_q <= fb_det;
      sts_q  <= (sts_q & ~clr) | ev;
      irq    <= |(sts_q & msk_q);
    end
  end

endmodule : psd_supervisor

// ---- test/psd_sup_asserts.sv ----
`timescale 1ns/1ps
module psd_sup_asserts #(
  parameter int unsigned TENTH_CYCLES = 10
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire psd_pkg::psd_word_t feedback,
  input wire logic [15:0]        clamped_input,
  input wire psd_pkg::psd_word_t freq_command,
  input wire logic               accelerating,
  input wire logic               decelerating,
  input wire logic               reverse_run,
  input wire logic               output_stop,
  input wire logic               dwell_hold,
  input wire logic               feedback_high_out,
  input wire logic               feedback_over_alarm
);
  import psd_pkg::*;
  localparam int unsigned HOLD_MAX = 100 * TENTH_CYCLES + 2;
  logic [31:0] hold_cnt_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // Longest dwell is 10.0 s plus launch slack
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hold_cnt_q <= '0;
    else if (dwell_hold)
      hold_cnt_q <= hold_cnt_q + 32'h1;
    else
      hold_cnt_q <= '0;
  AST_WAIT_STATE:
    assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not one wait state after access start");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  AST_ERR_QUAL:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_CLAMP_RANGE:
    assert property (!clamped_input[15] ? clamped_input <= 16'h2710 : clamped_input >= 16'hD8F0)
    else $error("clamped input beyond 1000 percent");
  AST_HIGH_CAUSE:
    assert property ($rose(feedback_high_out) |-> $past(feedback) != 16'h0000)
    else $error("feedback high without high feedback");
  AST_ALARM_WITH_OUT:
    assert property (feedback_over_alarm |-> feedback_high_out)
    else $error("over alarm without output function");
  AST_DIR_EXCL:
    assert property (!(reverse_run && output_stop)) else $error("reverse while stopped");
  AST_DWELL_CAUSE:
    assert property ($rose(dwell_hold) |-> $past(accelerating, 2) || $past(decelerating, 2))
    else $error("dwell without ramp");
  AST_DWELL_FREEZE:
    assert property (dwell_hold && $past(dwell_hold) |-> $stable(freq_command))
    else $error("command moved during dwell");
  AST_DWELL_LEN:
    assert property (hold_cnt_q <= HOLD_MAX) else $error("dwell too long");
endmodule : psd_sup_asserts

bind psd_supervisor psd_sup_asserts #(.TENTH_CYCLES(TENTH_CYCLES)) psd_sup_asserts_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .feedback(feedback), .clamped_input(clamped_input), .freq_command(freq_command),
  .accelerating(accelerating), .decelerating(decelerating), .reverse_run(reverse_run),
  .output_stop(output_stop), .dwell_hold(dwell_hold), .feedback_high_out(feedback_high_out),
  .feedback_over_alarm(feedback_over_alarm));

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "psd_regs.svh"
module tb;
  import psd_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic        pid_active = 1, motor2_select = 0, feedback_loss_alarm = 0, rerr;
  logic        accelerating = 0, decelerating = 0, reverse_run, output_stop, dwell_hold;
  logic        feedback_high_out, feedback_over_alarm;
  logic [15:0] controller_input = 0, controller_output = 0, clamped_input;
  psd_word_t   feedback = 0, target = 0, freq_reference = 0, output_frequency = 0;
  psd_word_t   reference_monitor, freq_command;
  logic [23:0] feedback_monitor, target_monitor;
  logic [1:0]  display_digits;
  int          fails = 0, checks = 0;
  logic [7:0]  ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28};
  logic [31:0] rv[10] = '{32'h208, 32'h2710, 32'hA03E8, 32'h22710, 32'hBB8, 32'h0, 32'h0,
                          32'h17701770, 32'h1770, 32'h0};

  always #12.5 clk = ~clk;

  psd_supervisor #(.TENTH_CYCLES(10)) psd_supervisor_i (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pid_active, .motor2_select,
    .feedback_loss_alarm, .accelerating, .decelerating, .controller_input, .feedback, .target,
    .controller_output, .freq_reference, .output_frequency, .clamped_input, .feedback_monitor,
    .target_monitor, .display_digits, .reference_monitor, .freq_command, .reverse_run,
    .output_stop, .dwell_hold, .feedback_high_out, .feedback_over_alarm, .irq);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Holds the request until pready is sampled, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never completes
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic results;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial
  begin
    #(25 * 5000);
    fails++;
    results;
  end

  initial
  begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'b0, 8'h30, 32'h0);
    chk(rerr, 1'b1);
    $display("test registers done");
    wr(`PSD_CTRL_OFF, 32'h209);
    wr(`PSD_INLIM_OFF, 32'h1F4);
    wr(`PSD_INLIM_OFF, 32'h2711);
    rd(`PSD_INLIM_OFF, 32'h1F4);
    controller_input <= 16'h07D0;
    cyc(3);
    chk(clamped_input, 16'h01F4);
    controller_input <= 16'hF830;
    cyc(3);
    chk(clamped_input, 16'hFE0C);
    controller_input <= 16'h012C;
    cyc(3);
    chk(clamped_input, 16'h012C);
    $display("test clamp done");
    wr(`PSD_UDISP_OFF, 32'h307D0);
    rd(`PSD_UDISP_OFF, 32'h22710);
    wr(`PSD_CTRL_OFF, 32'h609);
    wr(`PSD_UDISP_OFF, 32'h307D0);
    wr(`PSD_UDISP_OFF, 32'h3EA61);
    wr(`PSD_UDISP_OFF, 32'h30000);
    rd(`PSD_UDISP_OFF, 32'h307D0);
    feedback <= 16'h01F4;
    target <= 16'h0064;
    cyc(3);
    chk(feedback_monitor, 24'h0003E8);
    chk(target_monitor, 24'h0000C8);
    chk(display_digits, 2'h3);
    wr(`PSD_UDISP_OFF, 32'h2710);
    cyc(2);
    chk(display_digits, 2'h0);
    chk(feedback_monitor, 24'h001388);
    $display("test display done");
    wr(`PSD_CTRL_OFF, 32'h249);
    wr(`PSD_FBHI_OFF, 32'h200C8);
    feedback <= 16'h012C;
    cyc(15);
    chk(feedback_high_out, 1'b0);
    feedback <= 16'h00C8;
    cyc(1);
    feedback <= 16'h012C;
    cyc(15);
    chk(feedback_high_out, 1'b0);
    cyc(10);
    chk(feedback_high_out, 1'b1);
    chk(feedback_over_alarm, 1'b1);
    rd(`PSD_STATUS_OFF, 32'h3);
    rd(`PSD_INTSTS_OFF, 32'h1);
    chk(irq, 1'b0);
    wr(`PSD_INTMSK_OFF, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    wr(`PSD_INTSTS_OFF, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    feedback <= 16'h0064;
    cyc(3);
    chk(feedback_high_out, 1'b0);
    $display("test feedback high done");
    freq_reference <= 16'h03E8;
    controller_output <= 16'h00C8;
    wr(`PSD_CTRL_OFF, 32'h20B);
    cyc(2);
    chk(reference_monitor, 16'h04B0);
    wr(`PSD_CTRL_OFF, 32'h21B);
    cyc(2);
    chk(reference_monitor, 16'h03E8);
    controller_output <= 16'hFED4;
    cyc(3);
    chk(reverse_run, 1'b0);
    chk(freq_command, 16'h02BC);
    wr(`PSD_CTRL_OFF, 32'h209);
    cyc(2);
    chk(reverse_run, 1'b1);
    wr(`PSD_CTRL_OFF, 32'h201);
    cyc(2);
    chk({reverse_run, output_stop}, 2'b01);
    chk(freq_command, 16'h0000);
    wr(`PSD_CTRL_OFF, 32'h229);
    cyc(2);
    chk(reverse_run, 1'b0);
    $display("test direction done");
    controller_output <= 16'h00C8;
    wr(`PSD_CTRL_OFF, 32'h209);
    feedback_loss_alarm <= 1'b1;
    cyc(3);
    chk(freq_command, 16'h0BB8);
    wr(`PSD_UPLIM_OFF, 32'h7D0);
    cyc(2);
    chk(freq_command, 16'h07D0);
    wr(`PSD_UPLIM_OFF, 32'h1770);
    wr(`PSD_FMAX_OFF, 32'h05DC1770);
    motor2_select <= 1'b1;
    cyc(3);
    chk(freq_command, 16'h05DC);
    motor2_select <= 1'b0;
    feedback_loss_alarm <= 1'b0;
    cyc(3);
    chk(freq_command, 16'h00C8);
    rd(`PSD_INTSTS_OFF, 32'h2);
    wr(`PSD_INTSTS_OFF, 32'h2);
    $display("test fallback done");
    wr(`PSD_CTRL_OFF, 32'h208);
    freq_reference <= 16'h0BB8;
    wr(`PSD_SDWELL_OFF, 32'h203E8);
    accelerating <= 1'b1;
    output_frequency <= 16'h01F4;
    cyc(3);
    chk(dwell_hold, 1'b0);
    output_frequency <= 16'h03E8;
    cyc(3);
    chk({dwell_hold, freq_command}, {1'b1, 16'h03E8});
    cyc(12);
    chk(dwell_hold, 1'b1);
    cyc(10);
    chk({dwell_hold, freq_command}, {1'b0, 16'h0BB8});
    wr(`PSD_PDWELL_OFF, 32'h201F4);
    accelerating <= 1'b0;
    decelerating <= 1'b1;
    output_frequency <= 16'h0190;
    cyc(3);
    chk({dwell_hold, freq_command}, {1'b1, 16'h01F4});
    cyc(22);
    chk(dwell_hold, 1'b0);
    rd(`PSD_INTSTS_OFF, 32'hC);
    $display("test dwell done");
    results;
  end
endmodule : tb
